// *** core/dac_pkg.sv ***
// Shared constants and types of the converter control block.
// Assumes a word-wide AHB-Lite slave: byte address is four times the index.
package dac_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices
   localparam logic [3:0] IDX_CTRL_A = 4'h0;
   localparam logic [3:0] IDX_CTRL_B = 4'h1;
   localparam logic [3:0] IDX_EVENT_CONTROL = 4'h2;
   localparam logic [3:0] IDX_MASK_CLR = 4'h4;
   localparam logic [3:0] IDX_MASK_SET = 4'h5;
   localparam logic [3:0] IDX_FLAGS = 4'h6;
   localparam logic [3:0] IDX_STATUS = 4'h7;
   localparam logic [3:0] IDX_VALUE = 4'h8;
   localparam logic [3:0] IDX_STAGE = 4'hc;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CA_SOFT_RESET = 0;
   localparam int CA_ENABLE = 1;
   localparam int CA_STANDBY = 2;
   localparam int EV_START = 0;
   localparam int EV_DRAIN = 1;
   localparam int EV_INV_LSB = 4;
   localparam int FL_UNDERRUN = 0;
   localparam int FL_EMPTY = 1;
   localparam int FL_SYNC = 2;
   localparam int ST_ERROR = 0;
   localparam int ST_PENDING = 7;
   localparam int IRQ_N = 3;
   localparam int SAMPLE_W = 10;
   localparam int LEFT_LSB = 6;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [IRQ_N-1:0] RST_IRQ = 3'h0;

   ////////////////////////////////////////////////////////////////////////
   // Pending cross-domain operation
   localparam logic [1:0] OP_SOFT_RESET = 2'h0;
   localparam logic [1:0] OP_ENABLE = 2'h1;
   localparam logic [1:0] OP_VALUE = 2'h2;
   localparam logic [1:0] OP_STAGE = 2'h3;

   typedef struct packed {
      logic [1:0] ref_sel;
      logic rsvd;
      logic bypass_wp;
      logic pump_off;
      logic left_align;
      logic internal_out_en;
      logic external_out_en;
   } ctrl_b_s;

   typedef struct packed {
      logic [1:0] kind;
      logic [15:0] payload;
   } sync_op_s;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRITE = 3'b010,
      BUS_WAIT = 3'b100
   } bus_e;

endpackage

// *** core/dac_control.sv ***
// Control logic of a 10-bit converter: registers, flags, events, staging.
// Assumes one AHB-Lite master, synchronous pins except the event inputs.
module dac_control
   import dac_pkg::*;
#(
   parameter int EV_CH = 2,
   parameter int CONV_DIV = 4,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Event network
   input wire logic [EV_CH-1:0] event_in,
   output logic drain_event,
   // System state
   input wire logic standby,
   input wire logic low_voltage,
   // Host side requests
   output logic irq,
   output logic dma_req,
   // Converter core
   output logic conv_start,
   output logic [SAMPLE_W-1:0] dac_value,
   output logic out_buffer_en,
   output logic internal_out,
   output logic pump_on
);

   localparam logic [7:0] DIV_LAST = 8'(CONV_DIV - 1);

   ////////////////////////////////////////////////////////////////////////
   // Conversion-rate enable

   logic [7:0] div_cnt;
   logic conv_tick;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= 8'h00;
         conv_tick <= 1'b0;
      end else if (div_cnt == DIV_LAST) begin
         div_cnt <= 8'h00;
         conv_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 8'h01;
         conv_tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State declarations

   bus_e bus_state;
   logic [3:0] bus_idx;
   logic enable;
   logic standby_keep;
   ctrl_b_s cfg;
   logic [7:0] ev_ctrl;
   logic [IRQ_N-1:0] mask;
   logic [IRQ_N-1:0] flags;
   logic sync_err;
   logic sync_pending;
   sync_op_s op;
   logic enable_conv;
   logic [15:0] value;
   logic [15:0] stage;
   logic stage_full;
   logic start_req;
   logic [EV_CH-1:0] ev_s1;
   logic [EV_CH-1:0] ev_s2;
   logic [EV_CH-1:0] ev_s3;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return (a >> 6) == '0 && a[1:0] == 2'b00;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic accept;
   logic [3:0] addr_idx;
   logic wr_en;
   logic [7:0] wbyte;
   logic wr_ctrl_a;
   logic wr_sync;
   logic sync_ok;
   logic sync_done_now;
   logic soft_clr;
   logic transfer;
   logic [7:0] read_byte;

   assign accept = hsel & htrans[1] & hready;
   assign addr_idx = haddr[5:2];
   assign wr_en = bus_state == BUS_WRITE;
   assign wbyte = hwdata[7:0];
   assign wr_ctrl_a = wr_en && bus_idx == IDX_CTRL_A;
   assign wr_sync = wr_ctrl_a || (wr_en && (bus_idx == IDX_VALUE || bus_idx == IDX_STAGE));
   assign sync_ok = wr_sync && !sync_pending;
   assign sync_done_now = conv_tick && sync_pending;
   assign soft_clr = sync_done_now && op.kind == OP_SOFT_RESET;
   assign transfer = conv_tick && start_req && stage_full;

   always_comb begin
      case (addr_idx)
         IDX_CTRL_A:
            read_byte = {5'h00, standby_keep, enable, sync_pending && op.kind == OP_SOFT_RESET};
         IDX_CTRL_B: read_byte = cfg;
         IDX_EVENT_CONTROL: read_byte = ev_ctrl;
         IDX_MASK_CLR: read_byte = {5'h00, mask};
         IDX_MASK_SET: read_byte = {5'h00, mask};
         IDX_FLAGS: read_byte = {5'h00, flags};
         IDX_STATUS: read_byte = {sync_pending, 6'h00, sync_err};
         default: read_byte = RST_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero-wait except synchronized value reads

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus_state <= BUS_IDLE;
         bus_idx <= 4'h0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         case (bus_state)
            BUS_WAIT: begin
               if (conv_tick) begin
                  hrdata <= {16'h0000, value};
                  hreadyout <= 1'b1;
                  bus_state <= BUS_IDLE;
               end
            end
            default: begin
               if (accept && !mapped(haddr)) begin
                  bus_idx <= 4'h3;
                  hrdata <= 32'h0000_0000;
                  bus_state <= BUS_IDLE;
               end else if (accept && hwrite) begin
                  bus_idx <= addr_idx;
                  bus_state <= BUS_WRITE;
               end else if (accept && addr_idx == IDX_VALUE) begin
                  bus_idx <= addr_idx;
                  hreadyout <= 1'b0;
                  bus_state <= BUS_WAIT;
               end else if (accept && addr_idx == IDX_STAGE) begin
                  hrdata <= {16'h0000, stage};
                  bus_state <= BUS_IDLE;
               end else if (accept) begin
                  bus_idx <= addr_idx;
                  hrdata <= {24'h000000, read_byte};
                  bus_state <= BUS_IDLE;
               end else begin
                  bus_state <= BUS_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Plain configuration registers

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         enable <= 1'b0;
         standby_keep <= 1'b0;
         cfg <= RST_BYTE;
         ev_ctrl <= RST_BYTE;
      end else if (soft_clr) begin
         enable <= 1'b0;
         standby_keep <= 1'b0;
         cfg <= RST_BYTE;
         ev_ctrl <= RST_BYTE;
      end else begin
         if (wr_ctrl_a && !wbyte[CA_SOFT_RESET]) begin
            standby_keep <= wbyte[CA_STANDBY];
            if (sync_ok) begin
               enable <= wbyte[CA_ENABLE];
            end
         end
         // Enable-protected: changing config under a live converter glitches it
         if (wr_en && bus_idx == IDX_CTRL_B && !enable) begin
            cfg <= wbyte;
         end
         if (wr_en && bus_idx == IDX_EVENT_CONTROL && !enable) begin
            ev_ctrl <= wbyte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cross-domain operation tracking

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_pending <= 1'b0;
         op <= '0;
         sync_err <= 1'b0;
      end else begin
         if (sync_done_now) begin
            sync_pending <= 1'b0;
         end else if (sync_ok) begin
            sync_pending <= 1'b1;
            if (wr_ctrl_a && wbyte[CA_SOFT_RESET]) begin
               op <= '{kind: OP_SOFT_RESET, payload: RST_WORD};
            end else if (wr_ctrl_a) begin
               op <= '{kind: OP_ENABLE, payload: {15'h0000, wbyte[CA_ENABLE]}};
            end else if (bus_idx == IDX_VALUE) begin
               op <= '{kind: OP_VALUE, payload: hwdata[15:0]};
            end else begin
               op <= '{kind: OP_STAGE, payload: hwdata[15:0]};
            end
         end
         // Error is sticky until status is read or a soft reset completes; a new error wins
         if (wr_sync && sync_pending) begin
            sync_err <= 1'b1;
         end else if (soft_clr) begin
            sync_err <= 1'b0;
         end else if (accept && !hwrite && addr_idx == IDX_STATUS) begin
            sync_err <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Start event resynchronization and edge detection

   logic [EV_CH-1:0] ev_lvl;
   logic [EV_CH-1:0] ev_lvl_old;
   logic [EV_CH-1:0] ev_inv;

   assign ev_inv = ev_ctrl[EV_INV_LSB +: EV_CH];
   assign ev_lvl = ev_s2 ^ ev_inv;
   assign ev_lvl_old = ev_s3 ^ ev_inv;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ev_s1 <= '0;
         ev_s2 <= '0;
         ev_s3 <= '0;
      end else begin
         ev_s1 <= event_in;
         ev_s2 <= ev_s1;
         ev_s3 <= ev_s2;
      end
   end

   // Held until the converter side is ready on its next tick
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         start_req <= 1'b0;
      end else if (soft_clr) begin
         start_req <= 1'b0;
      end else if (|(ev_lvl & ~ev_lvl_old) && ev_ctrl[EV_START] && enable_conv) begin
         start_req <= 1'b1;
      end else if (conv_tick) begin
         start_req <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion side: two-entry queue of stage and value

   logic launch;
   logic drain_due;

   // Start trails the load by a cycle so the core never converts the old sample
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         launch <= 1'b0;
         drain_due <= 1'b0;
         enable_conv <= 1'b0;
         value <= RST_WORD;
         stage <= RST_WORD;
         stage_full <= 1'b0;
         conv_start <= 1'b0;
         drain_event <= 1'b0;
      end else if (soft_clr) begin
         enable_conv <= 1'b0;
         value <= RST_WORD;
         stage <= RST_WORD;
         stage_full <= 1'b0;
         conv_start <= 1'b0;
         drain_event <= 1'b0;
         launch <= 1'b0;
         drain_due <= 1'b0;
      end else begin
         launch <= transfer || (sync_done_now && op.kind == OP_VALUE);
         drain_due <= transfer && ev_ctrl[EV_DRAIN];
         conv_start <= launch;
         drain_event <= drain_due;
         if (transfer) begin
            value <= stage;
            stage_full <= 1'b0;
         end
         if (sync_done_now && op.kind == OP_ENABLE) begin
            enable_conv <= op.payload[0];
         end
         if (sync_done_now && op.kind == OP_VALUE) begin
            value <= op.payload;
         end
         if (sync_done_now && op.kind == OP_STAGE) begin
            stage <= op.payload;
            stage_full <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flags, mask and combined request

   logic [IRQ_N-1:0] flag_set;
   logic [IRQ_N-1:0] flag_clr;
   logic wr_flags;

   assign wr_flags = wr_en && bus_idx == IDX_FLAGS;
   assign flag_set[FL_UNDERRUN] = conv_tick && start_req && !stage_full;
   assign flag_set[FL_EMPTY] = !stage_full;
   assign flag_set[FL_SYNC] = sync_done_now;
   assign flag_clr = wr_flags ? wbyte[IRQ_N-1:0] : RST_IRQ;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags <= RST_IRQ;
      end else if (soft_clr) begin
         flags <= RST_IRQ;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask <= RST_IRQ;
      end else if (soft_clr) begin
         mask <= RST_IRQ;
      end else if (wr_en && bus_idx == IDX_MASK_SET) begin
         mask <= mask | wbyte[IRQ_N-1:0];
      end else if (wr_en && bus_idx == IDX_MASK_CLR) begin
         mask <= mask & ~wbyte[IRQ_N-1:0];
      end
   end

   // Registered, so one cycle after flags or mask change; needs no clock to hold
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // DMA request

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dma_req <= 1'b0;
      end else if (soft_clr) begin
         dma_req <= 1'b0;
      end else if (transfer) begin
         dma_req <= 1'b1;
      end else if (sync_done_now && op.kind == OP_ENABLE && op.payload[0] && !stage_full) begin
         dma_req <= 1'b1;
      end else if (wr_en && bus_idx == IDX_STAGE) begin
         dma_req <= 1'b0;
      end else if (wr_flags && wbyte[FL_EMPTY]) begin
         dma_req <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Analogue controls

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dac_value <= '0;
         out_buffer_en <= 1'b0;
         internal_out <= 1'b0;
         pump_on <= 1'b0;
      end else begin
         dac_value <= cfg.left_align ? value[LEFT_LSB +: SAMPLE_W]
                                     : value[SAMPLE_W-1:0];
         out_buffer_en <= enable_conv && cfg.external_out_en
                          && (!standby || standby_keep);
         internal_out <= enable_conv && cfg.internal_out_en;
         pump_on <= enable_conv && low_voltage && !cfg.pump_off;
      end
   end

endmodule

// *** verif/dac_control_checker.sv ***
// Port-level assertions for the converter control block.
// Assumes the bind below and a single clock domain.
module dac_control_checker
   import dac_pkg::*;
#(
   parameter int CONV_DIV = 4,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   // Core and system
   input wire logic low_voltage,
   input wire logic pump_on,
   input wire logic conv_start,
   input wire logic drain_event,
   input wire logic dma_req
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int WAIT_MAX = CONV_DIV + 1;
   logic [15:0] gap;
   logic value_rd;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   assign value_rd = hsel && htrans[1] && !hwrite && haddr[5:2] == IDX_VALUE
                     && (haddr >> 6) == '0;

   ////////////////////////////////////////////////////////////////////////
   // Cycles since the last conversion; starts at CONV_DIV so the first is legal
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         gap <= 16'(CONV_DIV);
      end else if (conv_start) begin
         gap <= 16'h0001;
      end else if (gap != 16'hffff) begin
         gap <= gap + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   AST_PUMP_NEEDS_LOW_V: assert property ($past(!low_voltage) |-> !pump_on)
      else $error("pump on without low supply");
   AST_START_PULSE: assert property (conv_start |=> !conv_start)
      else $error("conversion start longer than one cycle");
   AST_START_SPACING: assert property (conv_start |-> gap >= 16'(CONV_DIV))
      else $error("conversion started before converter ready");
   AST_DRAIN_PULSE: assert property (drain_event |=> !drain_event)
      else $error("drain event longer than one cycle");
   AST_DRAIN_WITH_START: assert property (drain_event |-> conv_start)
      else $error("drain event without a stage transfer");
   AST_DRAIN_DMA: assert property (drain_event |-> ##[0:1] dma_req)
      else $error("no dma request after stage transfer");
   AST_VALUE_READ_WAITS: assert property (value_rd && hready |=> !hreadyout)
      else $error("value read answered without synchronization");
   AST_WAIT_BOUNDED: assert property ($fell(hreadyout) |-> ##[1:WAIT_MAX] hreadyout)
      else $error("value read wait too long");
   AST_WAIT_ONLY_VALUE: assert property ($fell(hreadyout) |-> $past(value_rd))
      else $error("wait state on a register needing no read sync");
endmodule

bind dac_control dac_control_checker #(.CONV_DIV(CONV_DIV), .ADDR_W(ADDR_W)) chk_u (
   .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .low_voltage(low_voltage), .pump_on(pump_on), .conv_start(conv_start),
   .drain_event(drain_event), .dma_req(dma_req)
);

// *** verif/conv_core_model.sv ***
// Event network source and converter core observer.
// Assumes the bench calls fire() just after a rising edge.
module conv_core_model
   import dac_pkg::*;
#(
   parameter int EV_CH = 2,
   parameter logic [EV_CH-1:0] INV = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Core side
   input wire logic conv_start,
   input wire logic [SAMPLE_W-1:0] dac_value,
   input wire logic drain_event,
   // Event network
   output logic [EV_CH-1:0] event_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [EV_CH-1:0] lvl = '0;
   int starts;
   int drains;
   logic [SAMPLE_W-1:0] last;

   // Inverted channels rest high so their active edge is the fall
   assign event_in = lvl ^ INV;

   // Both edges are made; only the selected one must count
   task automatic fire(input int ch);
      lvl[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      lvl[ch] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         starts <= 0;
         drains <= 0;
         last <= '0;
      end else begin
         if (conv_start) begin
            starts <= starts + 1;
            last <= dac_value;
         end
         if (drain_event) begin
            drains <= drains + 1;
         end
      end
   end
endmodule

// *** verif/dac_control_bench.sv ***
// Self-checking bench: AHB-Lite register traffic, events, standby, pump.
// Assumes the checker is bound and the core model sources the events.
module dac_control_bench
   import dac_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DIV = 64;
   localparam logic [SAMPLE_W-1:0] SMP = 10'h2a5;
   logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp, standby, low_voltage;
   logic drain_event, irq, dma_req, conv_start, out_buffer_en, internal_out, pump_on;
   logic [7:0] haddr;
   logic [1:0] htrans, ev;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, d;
   logic [SAMPLE_W-1:0] dac_value;
   logic [7:0] zaddr [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1c, 8'h30, 8'h0c};
   ctrl_b_s cb = 8'h07;
   int fail_count = 0;
   int samples_checked = 0;

   assign hready = hreadyout;

   dac_control #(.CONV_DIV(DIV)) dut_u (
      .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .event_in(ev), .drain_event(drain_event),
      .standby(standby), .low_voltage(low_voltage), .irq(irq), .dma_req(dma_req),
      .conv_start(conv_start), .dac_value(dac_value), .out_buffer_en(out_buffer_en),
      .internal_out(internal_out), .pump_on(pump_on)
   );

   conv_core_model #(.INV(2'b01)) core_u (
      .clk(clk), .rst_b(rst_b), .conv_start(conv_start), .dac_value(dac_value),
      .drain_event(drain_event), .event_in(ev)
   );

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] ba(input logic [3:0] i);
      return {2'b00, i, 2'b00};
   endfunction

   // One single transfer; called just after a rising edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rdv);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      bus(a, 1'b1, wd, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] rdv);
      bus(a, 1'b0, 32'h0, rdv);
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // Poll until the pending cross-domain operation is done
   task automatic settle;
      logic [31:0] s;
      for (int i = 0; i < 40; i++) begin
         rd(ba(IDX_STATUS), s);
         if (s[ST_PENDING] === 1'b0) return;
      end
      chk(s, 32'h0);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic give_verdict;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      tick(20000);
      fail_count++;
      give_verdict;
   end

   initial begin
      {rst_b, hsel, hwrite, standby, low_voltage} = '0;
      haddr = '0;
      hsize = '0;
      htrans = '0;
      hwdata = '0;
      tick(10);
      rst_b <= 1'b1;
      tick(1);
      foreach (zaddr[i]) begin
         rd(zaddr[i], d);
         chk(d, 32'(RST_BYTE));
      end
      chk(32'(hresp), 32'h0);
      rd(ba(IDX_FLAGS), d);
      chk(d, 32'h1 << FL_EMPTY);
      rd(ba(IDX_VALUE), d);
      chk(d, 32'(RST_WORD));
      wr(ba(IDX_CTRL_B), 32'(cb));
      wr(ba(IDX_EVENT_CONTROL), 32'h13);
      wr(ba(IDX_STAGE), 32'(SMP) << LEFT_LSB);
      wr(ba(IDX_VALUE), 32'h55);
      rd(ba(IDX_STATUS), d);
      chk(d, 32'h81);
      settle;
      rd(ba(IDX_FLAGS), d);
      chk(d, 32'h6);
      wr(ba(IDX_FLAGS), 32'h0);
      rd(ba(IDX_FLAGS), d);
      chk(d, 32'h6);
      wr(ba(IDX_FLAGS), 32'h6);
      rd(ba(IDX_FLAGS), d);
      chk(d, 32'h0);
      rd(ba(IDX_VALUE), d);
      chk(d, 32'h0);
      low_voltage <= 1'b1;
      wr(ba(IDX_CTRL_A), 32'h2);
      settle;
      tick(2);
      chk(32'({internal_out, out_buffer_en, pump_on}), 32'h7);
      standby <= 1'b1;
      tick(3);
      chk(32'(out_buffer_en), 32'h0);
      wr(ba(IDX_CTRL_A), 32'h6);
      settle;
      tick(2);
      chk(32'(out_buffer_en), 32'h1);
      standby <= 1'b0;
      low_voltage <= 1'b0;
      tick(2);
      chk(32'(pump_on), 32'h0);
      // Enable-protected while running
      wr(ba(IDX_CTRL_B), 32'h0);
      rd(ba(IDX_CTRL_B), d);
      chk(d, 32'(cb));
      core_u.fire(1);
      tick(3 + DIV + 8);
      chk(core_u.starts, 1);
      chk(32'(core_u.last), 32'(SMP));
      chk(core_u.drains, 1);
      chk(32'(dma_req), 32'h1);
      rd(ba(IDX_FLAGS), d);
      chk(d & 32'h1, 32'h0);
      core_u.fire(0);
      tick(3 + DIV + 8);
      rd(ba(IDX_FLAGS), d);
      chk(d & 32'h1, 32'h1);
      chk(core_u.starts, 1);
      wr(ba(IDX_MASK_SET), 32'h1);
      tick(2);
      chk(32'(irq), 32'h1);
      wr(ba(IDX_MASK_CLR), 32'h0);
      tick(2);
      chk(32'(irq), 32'h1);
      wr(ba(IDX_MASK_CLR), 32'h1);
      tick(2);
      chk(32'(irq), 32'h0);
      wr(ba(IDX_MASK_SET), 32'h4);
      rd(ba(IDX_MASK_CLR), d);
      chk(d, 32'h4);
      chk(32'(irq), 32'h1);
      wr(ba(IDX_FLAGS), 32'h7);
      tick(2);
      chk(32'(irq), 32'h0);
      chk(32'(dma_req), 32'h0);
      wr(ba(IDX_VALUE), 32'h0123);
      settle;
      rd(ba(IDX_VALUE), d);
      chk(d, 32'h0123);
      chk(core_u.starts, 2);
      chk(32'(core_u.last), 32'h0123 >> LEFT_LSB);
      wr(ba(IDX_CTRL_A), 32'h3);
      settle;
      rd(ba(IDX_CTRL_A), d);
      chk(d, 32'h0);
      rd(ba(IDX_CTRL_B), d);
      chk(d, 32'h0);
      // Running with the start input disabled: events must be ignored
      wr(ba(IDX_CTRL_A), 32'h2);
      settle;
      chk(32'(dma_req), 32'h1);
      core_u.fire(1);
      tick(3 + DIV + 8);
      chk(core_u.starts, 2);
      rd(ba(IDX_FLAGS), d);
      chk(d & 32'h1, 32'h0);
      give_verdict;
   end
endmodule
